// ==== inc/bsd_regs.svh ====
// Register offsets, field positions and codes of the branch/special decoder
`ifndef BSD_REGS_SVH
`define BSD_REGS_SVH

// Register bus geometry
`define BSD_ADDR_W        5
`define BSD_DATA_W        16
`define BSD_NUM_REGS      8
`define BSD_IDX_W         3

// Register offsets
`define BSD_OFF_REG0      5'h00
`define BSD_OFF_REG7      5'h07
`define BSD_OFF_EB        5'h08
`define BSD_OFF_FB        5'h09
`define BSD_OFF_FIXED_EXT_BANK_REG     5'h0A
`define BSD_OFF_ADDR      5'h0B
`define BSD_OFF_STATUS    5'h0C
`define BSD_OFF_CONTROL   5'h0D

// Indices of hardware-loaded registers in the register file
`define BSD_IDX_G         3'h6
`define BSD_IDX_B         3'h7

// Bank register widths
`define BSD_EB_W          3
`define BSD_FB_W          5
`define BSD_FIXED_EXT_BANK_REG_W       3

// Word layout (bit numbers counted from 0)
`define BSD_BIT_SIGN      15
`define BSD_BIT_PAR       14
`define BSD_BIT_OC1       13
`define BSD_BIT_OC0       12
`define BSD_ADDR_MSB      11
`define BSD_MADDR_W       12
`define BSD_OC_W          3

// Special codes held in the buffer register, and the minus-zero word tested on the write lines
`define BSD_CODE_REL      16'h0003
`define BSD_CODE_INH      16'h0004
`define BSD_CODE_EXT      16'h0006
`define BSD_MINUS_ZERO    16'hFFFF

// Control register fields
`define BSD_CTL_PAR_EN    0
`define BSD_CTL_CLR_ALARM 1
`define BSD_CTL_CLR_FUT   2
`define BSD_CTL_RESET     16'h0001

`endif

// ==== inc/bsd_pkg.sv ====
// Types shared by the branch/special decoder modules
package bsd_pkg;

  // Decoded branch flip-flop patterns
  typedef struct packed {
    logic pat_01;
    logic pat_01_10;
    logic pat_10;
    logic pat_00;
  } bsd_branch_dec_s;

  // Fetching subinstructions, one bit each
  typedef struct packed {
    logic store_two;
    logic xfer;
    logic xfer_fixed;
    logic resume;
    logic mult;
    logic bzero;
    logic bzero_minus;
  } bsd_fetch_s;

  // Status word read by software
  typedef struct packed {
    logic       parity_alarm;
    logic       interrupt_inhibit;
    logic       future_extend;
    logic       special_ff;
    logic       branch_two;
  } bsd_status_s;

  typedef logic [15:0] bsd_word_t;

endpackage

// ==== verilog/bsd_parity.sv ====
// Odd parity generator and checker for one memory word
`timescale 1ns/1ns
`include "bsd_regs.svh"

module bsd_parity (
  input  wire logic [15:0] word_i,     // Word in memory layout
  output logic             par_gen_o,  // Parity bit that makes it odd
  output logic             par_ok_o    // Word including parity is odd
);

  // Parity over sign and value bits, parity slot excluded
  assign par_gen_o = ~(word_i[`BSD_BIT_SIGN]
                     ^ (^word_i[`BSD_BIT_OC1:0]));
  // Odd number of ones overall
  assign par_ok_o  = ^word_i;

endmodule // bsd_parity

// ==== verilog/bsd_branch_dec.sv ====
// Decoder of the two branch flip-flop states
`timescale 1ns/1ns

module bsd_branch_dec (
  input  wire logic                      br1_i,  // Branch one state
  input  wire logic                      br2_i,  // Branch two state
  output bsd_pkg::bsd_branch_dec_s       dec_o   // Decoded patterns
);

  // One decoded line per pattern, first bit is branch one
  assign dec_o.pat_01    = ~br1_i & br2_i;
  assign dec_o.pat_01_10 = br1_i ^ br2_i;
  assign dec_o.pat_10    = br1_i & ~br2_i;
  assign dec_o.pat_00    = ~br1_i & ~br2_i;

endmodule // bsd_branch_dec

// ==== verilog/bsd_branch_special.sv ====
// Branch test, special instruction recognition and processor registers
`timescale 1ns/1ns
`include "bsd_regs.svh"

module bsd_branch_special (
  input  wire logic              REF_CLK_I,         // 10 MHz clock
  input  wire logic              RST_N_I,           // Async reset, low
  // Register port
  input  wire logic [4:0]        REG_ADDR_I,        // Register offset
  input  wire logic [15:0]       REG_WDATA_I,       // Write data
  input  wire logic              REG_WR_I,          // Write strobe
  input  wire logic              REG_RD_I,          // Read strobe
  output logic [15:0]            REG_RDATA_O,       // Read data
  // Timing from the sequence generator
  input  wire logic              PHASE_THREE_I,     // Phase three
  input  wire logic              PHASE_FOUR_I,      // Phase four
  input  wire logic              TIME_SEVEN_PHASE_FOUR_I, // T7 phase 4
  input  wire logic              TIME_EIGHT_I,      // Time pulse 8
  input  wire logic              TIME_TWELVE_I,     // Time pulse 12
  // Branch test
  input  wire logic              MINUS_ZERO_TEST_PULSE_I, // Minus zero
  input  wire logic              SIGN_TEST_PULSE_I, // Sign test
  input  wire logic [15:0]       WRITE_LINES_I,     // Write lines
  input  wire logic              BRANCH_ONE_STATE_I, // Branch one ff
  output logic                   BRANCH_TWO_STATE_O, // Internal branch
  output logic                   BRANCH_TWO_MONITOR_OUT_O, // Monitor
  output bsd_pkg::bsd_branch_dec_s BRANCH_DECODE_O, // Decoded states
  // Fetching subinstructions
  input  bsd_pkg::bsd_fetch_s    FETCH_SUBINSTR_I,  // Active fetch
  output logic                   SPECIAL_RECOGNITION_ENABLE_O, // Enable
  output logic                   RELEASE_PULSE_O,   // Release code
  output logic                   INHIBIT_PULSE_O,   // Inhibit code
  output logic                   EXTEND_PULSE_O,    // Extend code
  output logic                   SPECIAL_FF_O,      // Special ff
  output logic                   READ_ADDRESS_PULSE_O, // Read address
  output logic                   SPECIAL_PATH_SIGNAL_O, // Special path
  output logic                   NORMAL_PATH_SIGNAL_O, // Normal path
  output logic                   READ_Z_PULSE_O,    // Read Z
  output logic                   STAGE_TWO_SET_PULSE_O, // Stage two
  output logic                   BUFFER_READ_PULSE_O, // Buffer read
  output logic                   WRITE_B_PULSE_O,   // Write B
  output logic                   FUTURE_EXTEND_FLAG_O, // Future extend
  output logic                   INTERRUPT_INHIBIT_O, // Inhibit ff
  // Memory side
  input  wire logic              MEM_READ_I,        // Memory word valid
  input  wire logic [15:0]       MEM_RDATA_I,       // Word from memory
  input  wire logic              MEM_WRITE_I,       // Write to memory
  output logic [15:0]            MEM_WDATA_O,       // Word with parity
  output logic                   PARITY_ALARM_O,    // Parity alarm
  // Decoded instruction
  output logic [2:0]             OPERATION_CODE_FIELD_O, // To sequencer
  output logic [11:0]            ADDRESS_REG_O,     // Memory address
  output logic [2:0]             ERASABLE_BANK_REG_O, // Erasable bank
  output logic [4:0]             FIXED_BANK_REG_O,  // Fixed bank
  output logic [2:0]             FIXED_EXT_BANK_REG_O // Extension bank
);

  ////////////////////////////////////////////////////////////////////
  // Reset synchroniser
  logic rst_meta_q;
  logic rst_n_q;

  // Release through two flip-flops
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Functions
  function automatic logic reg_hit(input logic [4:0] a,
                                   input logic [4:0] off);
    reg_hit = (a == off);
  endfunction

  // Memory layout to processor layout: sign copied into parity slot
  function automatic logic [15:0] to_cpu(input logic [15:0] w);
    to_cpu = w;
    to_cpu[`BSD_BIT_PAR] = w[`BSD_BIT_SIGN];
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Declarations
  logic [15:0]             regs_q [`BSD_NUM_REGS];
  logic                    br2_q;
  logic                    spc_q;
  logic                    fut_q;
  logic                    inh_q;
  logic                    alarm_q;
  logic [15:0]             ctl_q;
  logic [2:0]              eb_q;
  logic [4:0]              fb_q;
  logic [2:0]              fext_q;
  logic [11:0]             addr_q;
  logic [2:0]              oc_q;
  logic [15:0]             wdata_q;
  logic [15:0]             rdata_q;
  logic [15:0]             rdata_d;
  logic [15:0]             g_word;
  logic                    rec_en;
  logic                    recog;
  logic                    rel_p;
  logic                    inh_p;
  logic                    ext_p;
  logic                    any_p;
  logic                    read_address_pulse;
  logic                    spc_path;
  logic                    nrm_path;
  logic                    load_b;
  logic                    rd_par_ok;
  logic                    wr_par;
  logic [15:0]             wr_word;
  logic                    clr_alarm;
  logic                    clr_fut;
  logic                    wr_ctl;
  bsd_pkg::bsd_status_s    status;

  ////////////////////////////////////////////////////////////////////
  // Branch two flip-flop
  always_ff @(posedge REF_CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      br2_q <= 1'b0;
    end else if (MINUS_ZERO_TEST_PULSE_I && PHASE_THREE_I) begin
      br2_q <= 1'b0;
    end else if (MINUS_ZERO_TEST_PULSE_I && PHASE_FOUR_I) begin
      if (WRITE_LINES_I == `BSD_MINUS_ZERO) begin
        br2_q <= 1'b1;
      end
    end else if (SIGN_TEST_PULSE_I && PHASE_THREE_I) begin
      br2_q <= 1'b0;
    end else if (SIGN_TEST_PULSE_I && PHASE_FOUR_I) begin
      if (WRITE_LINES_I[`BSD_BIT_SIGN]) begin
        br2_q <= 1'b1;
      end
    end
    // Otherwise the last tested value is kept
  end

  // Branch outputs
  assign BRANCH_TWO_STATE_O       = br2_q;
  assign BRANCH_TWO_MONITOR_OUT_O = br2_q;

  // Pattern decoder
  bsd_branch_dec u_dec (
    .br1_i (BRANCH_ONE_STATE_I),
    .br2_i (br2_q),
    .dec_o (BRANCH_DECODE_O)
  );

  ////////////////////////////////////////////////////////////////////
  // Special instruction recognition
  assign rec_en = |FETCH_SUBINSTR_I;
  assign recog  = rec_en && TIME_SEVEN_PHASE_FOUR_I;
  assign g_word = regs_q[`BSD_IDX_G];

  // Codes are taken from the buffer register only
  assign rel_p = recog && (g_word == `BSD_CODE_REL);
  assign inh_p = recog && (g_word == `BSD_CODE_INH);
  assign ext_p = recog && (g_word == `BSD_CODE_EXT);
  assign any_p = rel_p || inh_p || ext_p;

  assign SPECIAL_RECOGNITION_ENABLE_O = rec_en;
  assign RELEASE_PULSE_O = rel_p;
  assign INHIBIT_PULSE_O = inh_p;
  assign EXTEND_PULSE_O  = ext_p;

  // Special flip-flop: set by a code at T7 phase 4, reset at T12 or at T7 phase 4 with no code
  always_ff @(posedge REF_CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      spc_q <= 1'b0;
    end else if (any_p) begin
      spc_q <= 1'b1;
    end else if (TIME_TWELVE_I || recog) begin
      spc_q <= 1'b0;
    end
  end

  assign SPECIAL_FF_O = spc_q;

  ////////////////////////////////////////////////////////////////////
  // Fetch path steering at T08
  assign read_address_pulse      = rec_en && TIME_EIGHT_I;
  assign spc_path = read_address_pulse && spc_q;
  assign nrm_path = read_address_pulse && !spc_q;
  assign load_b   = nrm_path;

  assign READ_ADDRESS_PULSE_O  = read_address_pulse;
  assign SPECIAL_PATH_SIGNAL_O = spc_path;
  assign NORMAL_PATH_SIGNAL_O  = nrm_path;
  assign READ_Z_PULSE_O        = spc_path;
  assign STAGE_TWO_SET_PULSE_O = spc_path;
  assign BUFFER_READ_PULSE_O   = nrm_path;
  assign WRITE_B_PULSE_O       = nrm_path;

  ////////////////////////////////////////////////////////////////////
  // Control register decode
  assign wr_ctl    = REG_WR_I && reg_hit(REG_ADDR_I, `BSD_OFF_CONTROL);
  assign clr_alarm = wr_ctl && REG_WDATA_I[`BSD_CTL_CLR_ALARM];
  assign clr_fut   = wr_ctl && REG_WDATA_I[`BSD_CTL_CLR_FUT];

  // Control register, only the enable bit is stored
  always_ff @(posedge REF_CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctl_q <= `BSD_CTL_RESET;
    end else if (wr_ctl) begin
      ctl_q <= 16'h0000;
      ctl_q[`BSD_CTL_PAR_EN] <= REG_WDATA_I[`BSD_CTL_PAR_EN];
    end
  end

  // Future-extend flag, set wins over software clear
  always_ff @(posedge REF_CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fut_q <= 1'b0;
    end else if (ext_p) begin
      fut_q <= 1'b1;
    end else if (clr_fut) begin
      fut_q <= 1'b0;
    end
  end

  // Interrupt inhibit flip-flop
  always_ff @(posedge REF_CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      inh_q <= 1'b0;
    end else if (inh_p) begin
      inh_q <= 1'b1;
    end else if (rel_p) begin
      inh_q <= 1'b0;
    end
  end

  assign FUTURE_EXTEND_FLAG_O = fut_q;
  assign INTERRUPT_INHIBIT_O  = inh_q;

  ////////////////////////////////////////////////////////////////////
  // Parity check on reads and generation on writes
  bsd_parity u_par_rd (
    .word_i    (MEM_RDATA_I),
    .par_gen_o (),
    .par_ok_o  (rd_par_ok)
  );

  bsd_parity u_par_wr (
    .word_i    (WRITE_LINES_I),
    .par_gen_o (wr_par),
    .par_ok_o  ()
  );

  // Written word carries generated parity in its own slot
  always_comb begin
    wr_word = WRITE_LINES_I;
    wr_word[`BSD_BIT_PAR] = wr_par;
  end

  // Registered memory write word
  always_ff @(posedge REF_CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wdata_q <= 16'h0000;
    end else if (MEM_WRITE_I) begin
      wdata_q <= wr_word;
    end
  end

  assign MEM_WDATA_O = wdata_q;

  // Sticky parity alarm, a new mismatch wins over clear
  always_ff @(posedge REF_CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      alarm_q <= 1'b0;
    end else if (MEM_READ_I && !rd_par_ok
                 && ctl_q[`BSD_CTL_PAR_EN]) begin
      alarm_q <= 1'b1;
    end else if (clr_alarm) begin
      alarm_q <= 1'b0;
    end
  end

  assign PARITY_ALARM_O = alarm_q;

  ////////////////////////////////////////////////////////////////////
  // Eight 16-bit registers; buffer and B loaded by hardware first
  always_ff @(posedge REF_CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (int i = 0; i < `BSD_NUM_REGS; i++) begin
        regs_q[i] <= 16'h0000;
      end
    end else begin
      if (REG_WR_I && (REG_ADDR_I <= `BSD_OFF_REG7)) begin
        regs_q[REG_ADDR_I[2:0]] <= REG_WDATA_I;
      end
      if (MEM_READ_I) begin
        // Parity slot replaced by sign inside the processor
        regs_q[`BSD_IDX_G] <= to_cpu(MEM_RDATA_I);
      end
      if (load_b) begin
        regs_q[`BSD_IDX_B] <= g_word;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Opcode and address register loaded on a normal fetch
  always_ff @(posedge REF_CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      oc_q   <= 3'h0;
      addr_q <= 12'h000;
    end else if (load_b) begin
      oc_q   <= {g_word[`BSD_BIT_SIGN],
                 g_word[`BSD_BIT_OC1],
                 g_word[`BSD_BIT_OC0]};
      addr_q <= g_word[`BSD_ADDR_MSB:0];
    end else if (REG_WR_I && reg_hit(REG_ADDR_I, `BSD_OFF_ADDR)) begin
      addr_q <= REG_WDATA_I[`BSD_ADDR_MSB:0];
    end
  end

  assign OPERATION_CODE_FIELD_O = oc_q;
  assign ADDRESS_REG_O          = addr_q;

  ////////////////////////////////////////////////////////////////////
  // Bank registers
  always_ff @(posedge REF_CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      eb_q   <= 3'h0;
      fb_q   <= 5'h00;
      fext_q <= 3'h0;
    end else if (REG_WR_I) begin
      if (reg_hit(REG_ADDR_I, `BSD_OFF_EB)) begin
        eb_q <= REG_WDATA_I[`BSD_EB_W-1:0];
      end
      if (reg_hit(REG_ADDR_I, `BSD_OFF_FB)) begin
        fb_q <= REG_WDATA_I[`BSD_FB_W-1:0];
      end
      if (reg_hit(REG_ADDR_I, `BSD_OFF_FIXED_EXT_BANK_REG)) begin
        fext_q <= REG_WDATA_I[`BSD_FIXED_EXT_BANK_REG_W-1:0];
      end
    end
  end

  assign ERASABLE_BANK_REG_O  = eb_q;
  assign FIXED_BANK_REG_O     = fb_q;
  assign FIXED_EXT_BANK_REG_O = fext_q;

  ////////////////////////////////////////////////////////////////////
  // Status word
  assign status.parity_alarm      = alarm_q;
  assign status.interrupt_inhibit = inh_q;
  assign status.future_extend     = fut_q;
  assign status.special_ff        = spc_q;
  assign status.branch_two        = br2_q;

  // Read mux, unmapped offsets read zero
  always_comb begin
    rdata_d = 16'h0000;
    if (REG_ADDR_I <= `BSD_OFF_REG7) begin
      rdata_d = regs_q[REG_ADDR_I[2:0]];
    end else begin
      unique case (REG_ADDR_I)
        `BSD_OFF_EB:      rdata_d = {13'h0000, eb_q};
        `BSD_OFF_FB:      rdata_d = {11'h000, fb_q};
        `BSD_OFF_FIXED_EXT_BANK_REG:   rdata_d = {13'h0000, fext_q};
        `BSD_OFF_ADDR:    rdata_d = {4'h0, addr_q};
        `BSD_OFF_STATUS:  rdata_d = {11'h000, status};
        `BSD_OFF_CONTROL: rdata_d = ctl_q;
        default:          rdata_d = 16'h0000;
      endcase
    end
  end

  // Read data register, valid the cycle after the strobe
  always_ff @(posedge REF_CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_q <= 16'h0000;
    end else if (REG_RD_I) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  assign REG_RDATA_O = rdata_q;

endmodule // bsd_branch_special

// ==== sim/bsd_monitor.sv ====
// Port checker of the branch and special-instruction decoder
`timescale 1ns/1ns
module bsd_monitor (
  input wire logic REF_CLK_I, RST_N_I, PHASE_THREE_I, PHASE_FOUR_I,
  input wire logic MINUS_ZERO_TEST_PULSE_I, SIGN_TEST_PULSE_I,
  input wire logic [15:0] WRITE_LINES_I,
  input wire logic BRANCH_ONE_STATE_I, BRANCH_TWO_STATE_O,
  input wire logic BRANCH_TWO_MONITOR_OUT_O, TIME_TWELVE_I,
  input bsd_pkg::bsd_branch_dec_s BRANCH_DECODE_O,
  input bsd_pkg::bsd_fetch_s FETCH_SUBINSTR_I,
  input wire logic SPECIAL_RECOGNITION_ENABLE_O, TIME_SEVEN_PHASE_FOUR_I,
  input wire logic RELEASE_PULSE_O, INHIBIT_PULSE_O, EXTEND_PULSE_O,
  input wire logic SPECIAL_FF_O, READ_ADDRESS_PULSE_O,
  input wire logic SPECIAL_PATH_SIGNAL_O, NORMAL_PATH_SIGNAL_O,
  input wire logic READ_Z_PULSE_O, STAGE_TWO_SET_PULSE_O,
  input wire logic BUFFER_READ_PULSE_O, WRITE_B_PULSE_O,
  input wire logic FUTURE_EXTEND_FLAG_O, INTERRUPT_INHIBIT_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);
  wire tst = MINUS_ZERO_TEST_PULSE_I | SIGN_TEST_PULSE_I;
  wire b1 = BRANCH_ONE_STATE_I;
  wire b2 = BRANCH_TWO_STATE_O;
  wire ff = SPECIAL_FF_O;
  ////////////////////////////////////////////////////////////////////////
  // Branch two test, hold and decode
  property p_clr; tst && PHASE_THREE_I |=> !b2; endproperty
  a_clr: assert property (p_clr) else $error("branch two kept");
  property p_mz;
    MINUS_ZERO_TEST_PULSE_I && PHASE_FOUR_I && !PHASE_THREE_I
      && (&WRITE_LINES_I) |=> b2;
  endproperty
  a_mz: assert property (p_mz) else $error("minus zero missed");
  property p_sgn;
    SIGN_TEST_PULSE_I && PHASE_FOUR_I && !PHASE_THREE_I
      && WRITE_LINES_I[15] |=> b2;
  endproperty
  a_sgn: assert property (p_sgn) else $error("sign missed");
  property p_hold; !tst |=> $stable(b2); endproperty
  a_hold: assert property (p_hold) else $error("branch two moved");
  property p_mon; BRANCH_TWO_MONITOR_OUT_O == b2; endproperty
  a_mon: assert property (p_mon) else $error("monitor differs");
  property p_dec;
    BRANCH_DECODE_O == {!b1 && b2, b1 != b2, b1 && !b2, !b1 && !b2};
  endproperty
  a_dec: assert property (p_dec) else $error("decode wrong");
  ////////////////////////////////////////////////////////////////////////
  // Special instruction recognition and fetch paths
  property p_en;
    SPECIAL_RECOGNITION_ENABLE_O == (|FETCH_SUBINSTR_I);
  endproperty
  a_en: assert property (p_en) else $error("enable wrong");
  property p_set;
    RELEASE_PULSE_O || INHIBIT_PULSE_O || EXTEND_PULSE_O |=> ff;
  endproperty
  a_set: assert property (p_set) else $error("special ff not set");
  property p_t12; TIME_TWELVE_I && !TIME_SEVEN_PHASE_FOUR_I |=> !ff;
  endproperty
  a_t12: assert property (p_t12) else $error("special ff kept");
  property p_flg;
    (INHIBIT_PULSE_O |=> INTERRUPT_INHIBIT_O)
      and (EXTEND_PULSE_O |=> FUTURE_EXTEND_FLAG_O)
      and (RELEASE_PULSE_O && !INHIBIT_PULSE_O |=> !INTERRUPT_INHIBIT_O);
  endproperty
  a_flg: assert property (p_flg) else $error("flag wrong");
  property p_rad;
    READ_ADDRESS_PULSE_O |-> {SPECIAL_PATH_SIGNAL_O, READ_Z_PULSE_O,
      STAGE_TWO_SET_PULSE_O} == {3{ff}} && {NORMAL_PATH_SIGNAL_O,
      BUFFER_READ_PULSE_O, WRITE_B_PULSE_O} == {3{!ff}};
  endproperty
  a_rad: assert property (p_rad) else $error("path");
  c_ext: cover property (EXTEND_PULSE_O);
  c_sp: cover property (SPECIAL_PATH_SIGNAL_O);
  c_np: cover property (NORMAL_PATH_SIGNAL_O);
endmodule // bsd_monitor

// ==== sim/bsd_seq_model.sv ====
// Sequence generator model giving time pulses 7, 8 and 12 of the twelve
`timescale 1ns/1ns
module bsd_seq_model (
  input  wire logic clk_i,   // Clock
  input  wire logic rst_n_i, // Reset, low
  output logic      t7p4_o,  // Time seven phase four
  output logic      t8_o,    // Time eight
  output logic      t12_o    // Time twelve
);
  logic [3:0] step_q;
  // Time pulse counter, steps 1 to 12
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      step_q <= 4'h1;
    else
      step_q <= (step_q == 4'hC) ? 4'h1 : step_q + 4'h1;
  end
  assign t7p4_o = rst_n_i && step_q == 4'h7;
  assign t8_o = rst_n_i && step_q == 4'h8;
  assign t12_o = rst_n_i && step_q == 4'hC;
endmodule // bsd_seq_model

// ==== sim/tb.sv ====
// Self-checking bench of the branch and special-instruction decoder
`timescale 1ns/1ns
module tb;
  logic REF_CLK_I = 0, RST_N_I = 0, REG_WR_I = 0, REG_RD_I = 0;
  logic PHASE_THREE_I = 0, PHASE_FOUR_I = 0, BRANCH_ONE_STATE_I = 0;
  logic MINUS_ZERO_TEST_PULSE_I = 0, SIGN_TEST_PULSE_I = 0;
  logic MEM_READ_I = 0, MEM_WRITE_I = 0;
  logic TIME_SEVEN_PHASE_FOUR_I, TIME_EIGHT_I, TIME_TWELVE_I;
  logic [4:0] REG_ADDR_I = 0, FIXED_BANK_REG_O;
  logic [15:0] REG_WDATA_I = 0, WRITE_LINES_I = 0, MEM_RDATA_I = 0;
  bsd_pkg::bsd_fetch_s FETCH_SUBINSTR_I = '0;
  bsd_pkg::bsd_branch_dec_s BRANCH_DECODE_O;
  logic [15:0] REG_RDATA_O, MEM_WDATA_O, d, w;
  logic [11:0] ADDRESS_REG_O;
  logic [2:0] OPERATION_CODE_FIELD_O, ERASABLE_BANK_REG_O, k, p;
  logic [2:0] FIXED_EXT_BANK_REG_O;
  logic [6:0] r;
  logic BRANCH_TWO_STATE_O, BRANCH_TWO_MONITOR_OUT_O, SPECIAL_FF_O, b, e;
  logic SPECIAL_RECOGNITION_ENABLE_O, RELEASE_PULSE_O, INHIBIT_PULSE_O;
  logic EXTEND_PULSE_O, READ_ADDRESS_PULSE_O, SPECIAL_PATH_SIGNAL_O;
  logic NORMAL_PATH_SIGNAL_O, READ_Z_PULSE_O, STAGE_TWO_SET_PULSE_O;
  logic BUFFER_READ_PULSE_O, WRITE_B_PULSE_O, FUTURE_EXTEND_FLAG_O;
  logic INTERRUPT_INHIBIT_O, PARITY_ALARM_O;
  int bad_count = 0, cmp_count = 0, ei = 0, ef = 0;
  logic [15:0] codes[$] = '{16'h0004, 16'h0003, 16'h0006};
  bsd_branch_special i_bsd_branch_special (.*);
  bsd_seq_model i_bsd_seq_model (.clk_i(REF_CLK_I), .rst_n_i(RST_N_I),
    .t7p4_o(TIME_SEVEN_PHASE_FOUR_I), .t8_o(TIME_EIGHT_I),
    .t12_o(TIME_TWELVE_I));
  always #50 REF_CLK_I = ~REF_CLK_I;
  ////////////////////////////////////////////////////////////////////////
  // Compare, bus tasks and verdict
  task automatic chk(input logic [15:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    REG_ADDR_I <= a;
    REG_WDATA_I <= v;
    REG_WR_I <= 1'b1;
    @(posedge REF_CLK_I);
    REG_WR_I <= 1'b0;
    @(posedge REF_CLK_I);
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] x);
    REG_ADDR_I <= a;
    REG_RD_I <= 1'b1;
    @(posedge REF_CLK_I);
    REG_RD_I <= 1'b0;
    @(negedge REF_CLK_I);
    chk(REG_RDATA_O, x);
    @(posedge REF_CLK_I);
  endtask
  task automatic end_sim;
    if (bad_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (5000) @(posedge REF_CLK_I);
    bad_count++;
    end_sim;
  end
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(32'h0D0E));
    repeat (3) @(posedge REF_CLK_I);
    RST_N_I <= 1'b1;
    repeat (3) @(posedge REF_CLK_I);
    for (int a = 8; a < 14; a++)
      rd(a[4:0], (a == 13) ? 16'h0001 : 16'h0000);
    rd(5'h1F, 16'h0000);
    wr(5'h0C, 16'hFFFF);
    rd(5'h0C, 16'h0000);
    // General registers below the buffer hold what is written
    for (int i = 0; i < 6; i++) begin
      w = 16'($urandom);
      wr(i[4:0], w);
      rd(i[4:0], w);
    end
    for (int i = 0; i < 3; i++) begin
      w = 16'($urandom);
      wr(5'h08 + i[4:0], w);
      rd(5'h08 + i[4:0], w & ((i == 1) ? 16'h001F : 16'h0007));
      d = 16'((i == 0) ? ERASABLE_BANK_REG_O : (i == 1) ? FIXED_BANK_REG_O
        : FIXED_EXT_BANK_REG_O);
      chk(d, w & ((i == 1) ? 16'h001F : 16'h0007));
    end
    // Branch tests, minus zero on even passes, sign on odd
    for (int i = 0; i < 16; i++) begin
      w = (i == 0) ? 16'hFFFF : (i == 2) ? 16'h7FFF : 16'($urandom);
      b = 1'($urandom);
      e = i[0] ? w[15] : &w;
      MINUS_ZERO_TEST_PULSE_I <= !i[0];
      SIGN_TEST_PULSE_I <= i[0];
      PHASE_THREE_I <= 1'b1;
      BRANCH_ONE_STATE_I <= b;
      @(posedge REF_CLK_I);
      PHASE_THREE_I <= 1'b0;
      PHASE_FOUR_I <= 1'b1;
      WRITE_LINES_I <= w;
      @(posedge REF_CLK_I);
      PHASE_FOUR_I <= 1'b0;
      MINUS_ZERO_TEST_PULSE_I <= 1'b0;
      SIGN_TEST_PULSE_I <= 1'b0;
      repeat (2) @(negedge REF_CLK_I);
      chk(16'(BRANCH_TWO_STATE_O), 16'(e));
      chk(16'(BRANCH_DECODE_O), 16'({~b & e, b ^ e, b & ~e, ~b & ~e}));
      @(posedge REF_CLK_I);
    end
    // Special codes, then random words on the normal path
    for (int i = 0; i < 10; i++) begin
      w = (i < 3) ? codes[i] : 16'($urandom);
      k = {w == 16'h0003, w == 16'h0004, w == 16'h0006};
      wr(5'h06, w);
      FETCH_SUBINSTR_I <= 7'h01 << (i % 7);
      @(negedge REF_CLK_I);
      while (!TIME_SEVEN_PHASE_FOUR_I) @(negedge REF_CLK_I);
      chk(16'(SPECIAL_FF_O), 16'h0000);
      p = {RELEASE_PULSE_O, INHIBIT_PULSE_O, EXTEND_PULSE_O};
      chk(16'(p), 16'(k));
      if (k[1])
        ei = 1;
      else if (k[2])
        ei = 0;
      if (k[0])
        ef = 1;
      @(negedge REF_CLK_I);
      p = {SPECIAL_FF_O, INTERRUPT_INHIBIT_O, FUTURE_EXTEND_FLAG_O};
      chk(16'(p), 16'({|k, ei[0], ef[0]}));
      r = {READ_ADDRESS_PULSE_O, SPECIAL_PATH_SIGNAL_O, READ_Z_PULSE_O,
        STAGE_TWO_SET_PULSE_O, NORMAL_PATH_SIGNAL_O, BUFFER_READ_PULSE_O,
        WRITE_B_PULSE_O};
      chk(16'(r), 16'({1'b1, {3{|k}}, {3{~|k}}}));
      @(posedge REF_CLK_I);
      FETCH_SUBINSTR_I <= '0;
      if (k == 3'h0) begin
        rd(5'h07, w);
        d = 16'({OPERATION_CODE_FIELD_O, ADDRESS_REG_O});
        chk(d, 16'({w[15], w[13:0]}));
      end
    end
    // Memory reads: odd word passes, even word alarms
    for (int i = 0; i < 2; i++) begin
      w = i ? 16'h8001 : 16'h0001;
      MEM_RDATA_I <= w;
      MEM_READ_I <= 1'b1;
      @(posedge REF_CLK_I);
      MEM_READ_I <= 1'b0;
      @(posedge REF_CLK_I);
      rd(5'h06, {w[15], w[15], w[13:0]});
      chk(16'(PARITY_ALARM_O), 16'(i));
    end
    wr(5'h0D, 16'h0007);
    chk(16'({PARITY_ALARM_O, FUTURE_EXTEND_FLAG_O}), 16'h0000);
    // Memory writes get odd parity in bit 14
    for (int i = 0; i < 4; i++) begin
      w = 16'($urandom);
      WRITE_LINES_I <= w;
      MEM_WRITE_I <= 1'b1;
      @(posedge REF_CLK_I);
      MEM_WRITE_I <= 1'b0;
      repeat (2) @(negedge REF_CLK_I);
      chk(MEM_WDATA_O, {w[15], ~^{w[15], w[13:0]}, w[13:0]});
      @(posedge REF_CLK_I);
    end
    end_sim;
  end
endmodule // tb
bind bsd_branch_special bsd_monitor i_bsd_monitor (.*);
